// file: core/fpc_cvt.v
`timescale 1ns/1ps
`include "fpc_defs.vh"

module fpc_cvt
(
  // Raw operand, last byte received in bits 7:0
  input wire [2:0] fmt,
  input wire [95:0] raw,
  // Extended result: sign, 15-bit exponent, 64-bit mantissa
  output reg [79:0] ext
);

reg [31:0] ival;
reg [31:0] mag;
reg [5:0] msb;
reg [63:0] mant;
reg [14:0] e;
integer i;

always @*
begin
  ival = 32'h0000_0000;
  mag = 32'h0000_0000;
  msb = 6'h00;
  mant = 64'h0000_0000_0000_0000;
  e = 15'h0000;
  ext = 80'h0;
  case (fmt)
    `FPC_FMT_BYTE, `FPC_FMT_WORD, `FPC_FMT_LONG:
    begin
      if (fmt == `FPC_FMT_BYTE)
        ival = {{24{raw[7]}}, raw[7:0]};
      else if (fmt == `FPC_FMT_WORD)
        ival = {{16{raw[15]}}, raw[15:0]};
      else
        ival = raw[31:0];
      mag = ival[31] ? (~ival + 32'h0000_0001) : ival;
      for (i = 0; i < 32; i = i + 1)
        if (mag[i])
          msb = i[5:0];
      mant = {mag, 32'h0000_0000} << (6'h1f - msb);
      if (mag != 32'h0000_0000)
        ext = {ival[31], `FPC_BIAS_EXT + {9'h000, msb}, mant};
    end
    `FPC_FMT_SGL:
    begin
      e = `FPC_BIAS_EXT - `FPC_BIAS_SGL + {7'h00, raw[30:23]};
      mant = {1'b1, raw[22:0], 40'h00_0000_0000};
      if (raw[30:23] == 8'hff)
        ext = {raw[31], `FPC_EXP_MAX, mant};
      else if (raw[30:23] == 8'h00)
        ext = {raw[31], (raw[22:0] == 23'h0) ? 15'h0000 :
               e + 15'h0001, 1'b0, raw[22:0], 40'h00_0000_0000};
      else
        ext = {raw[31], e, mant};
    end
    `FPC_FMT_DBL:
    begin
      e = `FPC_BIAS_EXT - `FPC_BIAS_DBL + {4'h0, raw[62:52]};
      mant = {1'b1, raw[51:0], 11'h000};
      if (raw[62:52] == 11'h7ff)
        ext = {raw[63], `FPC_EXP_MAX, mant};
      else if (raw[62:52] == 11'h000)
        ext = {raw[63], (raw[51:0] == 52'h0) ? 15'h0000 :
               e + 15'h0001, 1'b0, raw[51:0], 11'h000};
      else
        ext = {raw[63], e, mant};
    end
    // sign, 15-bit exponent, explicit 64-bit mantissa
    // three long words, 16 pad bits dropped
    `FPC_FMT_EXT:
      ext = {raw[95], raw[94:80], raw[63:0]};
    default:
      ext = 80'h0;
  endcase
end

endmodule // fpc_cvt

// file: core/fpc_defs.vh
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH

// Host bus decode
`define FPC_FC_CPU_SPACE 3'h7
`define FPC_DEF_COPROC_ID 3'h1

// Interface register indices (coproc_interface_register)
`define FPC_IFR_RESP 4'h0
`define FPC_IFR_SAVE 4'h1
`define FPC_IFR_RESTORE 4'h2
`define FPC_IFR_CMD 4'h3
`define FPC_IFR_OPND 4'h4

// Host transfer sizes
`define FPC_SZ_BYTE 2'h0
`define FPC_SZ_WORD 2'h1
`define FPC_SZ_LONG 2'h2

// Command word fields
`define FPC_CMD_MEM_BIT 15
`define FPC_CMD_FMT_HI 14
`define FPC_CMD_FMT_LO 12

// Operand format codes
`define FPC_FMT_BYTE 3'h0
`define FPC_FMT_WORD 3'h1
`define FPC_FMT_LONG 3'h2
`define FPC_FMT_SGL 3'h3
`define FPC_FMT_DBL 3'h4
`define FPC_FMT_EXT 3'h5

// Response words
`define FPC_RSP_DONE 16'h0000
`define FPC_RSP_WAIT 16'h8000
`define FPC_RSP_FETCH 16'h4000
`define FPC_RSP_ERROR 16'h2000

// Save frame format words: version in [31:24], length in words in [5:0]
`define FPC_FRAME_VER 8'h5a
`define FPC_FRAME_RESET 32'h0000_0000
`define FPC_FRAME_AGAIN 32'h0100_0000
`define FPC_FRAME_IDLE_TAG 8'h01
`define FPC_FRAME_BUSY_TAG 8'h02
`define FPC_IDLE_WORDS 6'h07
`define FPC_BUSY_WORDS 6'h2e
`define FPC_BUSY_SAVE_CYC 8'h2e

// Floating-point layout
`define FPC_BIAS_SGL 15'h007f
`define FPC_BIAS_DBL 15'h03ff
`define FPC_BIAS_EXT 15'h3fff
`define FPC_EXP_MAX 15'h7fff

`endif

// file: core/fpc_port.v
`timescale 1ns/1ps
`include "fpc_defs.vh"

// Summary of operation
// - Works on 8, 16 or 32 bit host bus using plain transfers.
// - Response asks for operand transfers; host fulfils each first.
// - Response says wait while previous operands not yet handed over.
// - CPU-space code and three id lines select one of eight units.
// - Never a bus master; host performs every fetch and store.
// - Full handshake lets host and coprocessor clocks differ.
// - Context save halts an operation with over 46 cycles left, even mid-instruction.
// - Save in reset state gives one word marking an empty model.
// - Save while idle gives a short idle frame.
// - Save during calculation gives the full busy frame.
// - Nearly finished instruction completes first; idle frame is saved.
// - Restore reloads a frame and resumes suspended work.
// - Restoring the reset frame acts as a hardware reset.
// - Idle and busy frames open with a format word unique to this unit.
// - Integer operands convert to extended format before use.
// - Single and double follow IEEE layouts, 8 and 11 bit exponents.
// - Biases 127, 1023, 16383; mantissas sign-magnitude.
// - Single and double mantissas imply the leading one.
// - Extended holds 15-bit exponent, 64-bit mantissa, sign bit.
// - Extended occupies 96 bits in memory, 16 unused.
// - Single-step and trace leave instruction behaviour unchanged.

module fpc_port
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Host bus
  input wire host_as_n,
  input wire host_ds_n,
  input wire host_rw,
  input wire [2:0] host_fc,
  input wire [2:0] host_id,
  input wire [3:0] host_reg,
  input wire [1:0] host_size,
  input wire [31:0] host_wdata,
  output reg host_dsack_n_r,
  output reg [31:0] host_rdata_r,
  // Execution unit
  input wire exec_busy,
  input wire [7:0] exec_remain,
  output reg exec_start_r,
  output reg [15:0] exec_cmd_r,
  output reg [79:0] exec_opnd_r,
  output reg exec_halt_r,
  output reg exec_resume_r,
  output reg exec_reset_r,
  // Context store of the execution unit
  input wire [31:0] ctx_rdata,
  output reg [5:0] ctx_addr_r,
  output reg ctx_wr_r,
  output reg [31:0] ctx_wdata_r
);

// ----------------------------------------
// States
// ----------------------------------------
localparam ST_IDLE = 2'b00;
localparam ST_OPND = 2'b01;
localparam ST_SAVE = 2'b10;
localparam ST_RSTR = 2'b11;

reg [1:0] state_r;
reg [15:0] resp_r;
reg [95:0] raw_r;
reg [95:0] raw_nxt;
reg [3:0] need_r;
reg [3:0] take;
reg [5:0] cnt_r;
reg live_r;
reg hand_pend_r;
reg busy_frame_r;
reg [3:0] len;
wire hit;
wire [3:0] reg_idx;
wire [79:0] cvt_ext;
wire acc;
wire [2:0] cmd_fmt;

// ----------------------------------------
// Decode and conversion
// ----------------------------------------
fpc_sel u_sel
(
  .fc(host_fc),
  .id(host_id),
  .my_id(`FPC_DEF_COPROC_ID),
  .reg_addr(host_reg),
  .hit(hit),
  .reg_idx(reg_idx)
);

fpc_cvt u_cvt
(
  .fmt(exec_cmd_r[`FPC_CMD_FMT_HI:`FPC_CMD_FMT_LO]),
  .raw(raw_r),
  .ext(cvt_ext)
);

// new cycle only after strobe release
assign acc = hit && !host_as_n && !host_ds_n && host_dsack_n_r;
assign cmd_fmt = host_wdata[`FPC_CMD_FMT_HI:`FPC_CMD_FMT_LO];

// ----------------------------------------
// Operand length and byte assembly
// ----------------------------------------
always @*
begin
  case (cmd_fmt)
    `FPC_FMT_BYTE: len = 4'h1;
    `FPC_FMT_WORD: len = 4'h2;
    `FPC_FMT_LONG: len = 4'h4;
    `FPC_FMT_SGL: len = 4'h4;
    `FPC_FMT_DBL: len = 4'h8;
    `FPC_FMT_EXT: len = 4'hc;
    default: len = 4'h4;
  endcase
end

always @*
begin
  case (host_size)
    `FPC_SZ_BYTE:
    begin
      raw_nxt = {raw_r[87:0], host_wdata[7:0]};
      take = 4'h1;
    end
    `FPC_SZ_WORD:
    begin
      raw_nxt = {raw_r[79:0], host_wdata[15:0]};
      take = 4'h2;
    end
    default:
    begin
      raw_nxt = {raw_r[63:0], host_wdata};
      take = 4'h4;
    end
  endcase
end

// ----------------------------------------
// Main sequencer
// ----------------------------------------
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    state_r <= ST_IDLE;
    resp_r <= `FPC_RSP_DONE;
    raw_r <= 96'h0;
    need_r <= 4'h0;
    cnt_r <= 6'h00;
    live_r <= 1'b0;
    hand_pend_r <= 1'b0;
    busy_frame_r <= 1'b0;
    host_dsack_n_r <= 1'b1;
    host_rdata_r <= 32'h0000_0000;
    exec_start_r <= 1'b0;
    exec_cmd_r <= 16'h0000;
    exec_opnd_r <= 80'h0;
    exec_halt_r <= 1'b0;
    exec_resume_r <= 1'b0;
    exec_reset_r <= 1'b0;
    ctx_addr_r <= 6'h00;
    ctx_wr_r <= 1'b0;
    ctx_wdata_r <= 32'h0000_0000;
  end
  else
  begin
    exec_start_r <= 1'b0;
    exec_halt_r <= 1'b0;
    exec_resume_r <= 1'b0;
    exec_reset_r <= 1'b0;
    ctx_wr_r <= 1'b0;
    if (host_ds_n)
      host_dsack_n_r <= 1'b1;
    // hand over only; no bus mastering
    if (hand_pend_r && !exec_busy && !exec_start_r)
    begin
      exec_start_r <= 1'b1;
      exec_opnd_r <= cvt_ext;
      hand_pend_r <= 1'b0;
    end
    if (acc)
    begin
      host_dsack_n_r <= 1'b0;
      host_rdata_r <= 32'h0000_0000;
      if (!host_rw)
      begin
        case (reg_idx)
          `FPC_IFR_CMD:
          begin
            if (hand_pend_r || state_r != ST_IDLE)
              resp_r <= `FPC_RSP_WAIT;
            else
            begin
              exec_cmd_r <= host_wdata[15:0];
              live_r <= 1'b1;
              raw_r <= 96'h0;
              if (host_wdata[`FPC_CMD_MEM_BIT])
              begin
                state_r <= ST_OPND;
                need_r <= len;
                resp_r <= `FPC_RSP_FETCH | {12'h000, len};
              end
              else
              begin
                hand_pend_r <= 1'b1;
                resp_r <= `FPC_RSP_DONE;
              end
            end
          end
          `FPC_IFR_OPND:
          begin
            if (state_r == ST_OPND)
            begin
              raw_r <= raw_nxt;
              if (need_r <= take)
              begin
                need_r <= 4'h0;
                state_r <= ST_IDLE;
                hand_pend_r <= 1'b1;
                resp_r <= `FPC_RSP_DONE;
              end
              else
                need_r <= need_r - take;
            end
            else if (state_r == ST_RSTR)
            begin
              ctx_wr_r <= 1'b1;
              ctx_wdata_r <= host_wdata;
              ctx_addr_r <= cnt_r - 6'h01;
              cnt_r <= cnt_r - 6'h01;
              if (cnt_r == 6'h01)
              begin
                state_r <= ST_IDLE;
                exec_resume_r <= busy_frame_r;
              end
            end
          end
          `FPC_IFR_RESTORE:
          begin
            if (host_wdata == `FPC_FRAME_RESET)
            begin
              // restore of reset frame clears command and operand state, resets execution unit
              state_r <= ST_IDLE;
              resp_r <= `FPC_RSP_DONE;
              raw_r <= 96'h0;
              need_r <= 4'h0;
              live_r <= 1'b0;
              hand_pend_r <= 1'b0;
              exec_cmd_r <= 16'h0000;
              exec_opnd_r <= 80'h0;
              exec_reset_r <= 1'b1;
            end
            else if (host_wdata[31:24] == `FPC_FRAME_VER &&
                     (host_wdata[15:8] == `FPC_FRAME_IDLE_TAG ||
                      host_wdata[15:8] == `FPC_FRAME_BUSY_TAG))
            begin
              state_r <= ST_RSTR;
              live_r <= 1'b1;
              hand_pend_r <= 1'b0;
              busy_frame_r <= host_wdata[15:8] == `FPC_FRAME_BUSY_TAG;
              cnt_r <= host_wdata[5:0];
            end
            else
              resp_r <= `FPC_RSP_ERROR;
          end
          default:
            resp_r <= resp_r;
        endcase
      end
      else
      begin
        case (reg_idx)
          `FPC_IFR_RESP:
            host_rdata_r <= {16'h0000, resp_r};
          `FPC_IFR_SAVE:
          begin
            if (!live_r)
              host_rdata_r <= `FPC_FRAME_RESET;
            else if (exec_busy || hand_pend_r)
            begin
              if (hand_pend_r || exec_remain <= `FPC_BUSY_SAVE_CYC)
                host_rdata_r <= `FPC_FRAME_AGAIN;
              else
              begin
                exec_halt_r <= 1'b1;
                state_r <= ST_SAVE;
                cnt_r <= `FPC_BUSY_WORDS;
                ctx_addr_r <= `FPC_BUSY_WORDS - 6'h01;
                host_rdata_r <= {`FPC_FRAME_VER, 8'h00,
                  `FPC_FRAME_BUSY_TAG, 2'b00, `FPC_BUSY_WORDS};
              end
            end
            else
            begin
              state_r <= ST_SAVE;
              need_r <= 4'h0;
              cnt_r <= `FPC_IDLE_WORDS;
              ctx_addr_r <= `FPC_IDLE_WORDS - 6'h01;
              host_rdata_r <= {`FPC_FRAME_VER, 8'h00,
                `FPC_FRAME_IDLE_TAG, 2'b00, `FPC_IDLE_WORDS};
            end
          end
          `FPC_IFR_OPND:
          begin
            if (state_r == ST_SAVE)
            begin
              host_rdata_r <= ctx_rdata;
              ctx_addr_r <= ctx_addr_r - 6'h01;
              cnt_r <= cnt_r - 6'h01;
              if (cnt_r == 6'h01)
                state_r <= ST_IDLE;
            end
          end
          default:
            host_rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end
end

endmodule // fpc_port

// file: core/fpc_sel.v
`timescale 1ns/1ps
`include "fpc_defs.vh"

module fpc_sel
(
  // Host address
  input wire [2:0] fc,
  input wire [2:0] id,
  input wire [2:0] my_id,
  input wire [3:0] reg_addr,
  // Decode result
  output wire hit,
  output wire [3:0] reg_idx
);

// ----------------------------------------
// CPU space and identifier decode
// ----------------------------------------
// id and space decode
assign hit = (fc == `FPC_FC_CPU_SPACE) && (id == my_id);
assign reg_idx = reg_addr;

endmodule // fpc_sel

// file: testbench/fpc_host_model.sv
`timescale 1ns/1ps
module fpc_host_model
(
  // Clock
  input wire sys_clk,
  // Host bus
  input wire host_dsack_n_r,
  input wire [31:0] host_rdata_r,
  output reg host_as_n = 1'b1,
  output reg host_ds_n = 1'b1,
  output reg host_rw = 1'b1,
  output reg [2:0] host_fc = 3'h0,
  output reg [2:0] host_id = 3'h0,
  output reg [3:0] host_reg = 4'h0,
  output reg [1:0] host_size = 2'h0,
  output reg [31:0] host_wdata = 32'h0000_0000
);
  task acc(input rw, input [3:0] r, input [1:0] sz, input [31:0] d,
    input [2:0] f, input [2:0] i, output [31:0] q, output ok);
    integer n;
    begin
      @(negedge sys_clk);
      {host_rw, host_reg, host_size, host_wdata} = {rw, r, sz, d};
      {host_fc, host_id, host_as_n, host_ds_n} = {f, i, 2'b00};
      ok = 1'b0;
      q = 32'h0000_0000;
      n = 0;
      while (!ok && n < 16)
      begin
        @(posedge sys_clk);
        n = n + 1;
        if (host_dsack_n_r === 1'b0)
        begin
          ok = 1'b1;
          q = host_rdata_r;
        end
      end
      @(negedge sys_clk);
      {host_as_n, host_ds_n} = 2'b11;
      host_wdata = ~host_wdata;
      repeat (2) @(negedge sys_clk);
    end
  endtask
endmodule // fpc_host_model

// file: testbench/fpc_port_monitor.sv
`timescale 1ns/1ps
`include "fpc_defs.vh"
module fpc_port_monitor
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Host bus
  input wire host_as_n,
  input wire host_ds_n,
  input wire [2:0] host_fc,
  input wire [2:0] host_id,
  input wire host_dsack_n_r,
  input wire [31:0] host_rdata_r,
  // Execution unit
  input wire exec_busy,
  input wire [7:0] exec_remain,
  input wire exec_start_r,
  input wire exec_halt_r,
  input wire exec_resume_r,
  input wire exec_reset_r,
  input wire ctx_wr_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire sel = !host_as_n && !host_ds_n && host_fc == 3'h7 && host_id == 3'h1;
  a_sel_ack_next: assert property (
    sel && host_dsack_n_r |=> !host_dsack_n_r)
    else $error("selected access not acknowledged");
  a_unsel_no_ack: assert property (
    !sel && host_dsack_n_r |=> host_dsack_n_r)
    else $error("acknowledge without selection");
  a_ack_holds: assert property (
    !host_dsack_n_r && !host_ds_n |=> !host_dsack_n_r)
    else $error("acknowledge dropped early");
  a_ack_ends: assert property (
    host_ds_n [*3] |-> host_dsack_n_r)
    else $error("acknowledge stuck");
  a_rdata_holds: assert property (
    !host_dsack_n_r && !$past(host_dsack_n_r) |-> $stable(host_rdata_r))
    else $error("read data moved");
  a_start_when_free: assert property (
    exec_start_r |-> !$past(exec_busy))
    else $error("handoff while busy");
  a_start_pulse: assert property (
    exec_start_r |=> !exec_start_r)
    else $error("handoff pulse too long");
  a_halt_long_only: assert property (
    exec_halt_r |-> $past(exec_busy) &&
    $past(exec_remain) > `FPC_BUSY_SAVE_CYC)
    else $error("needless halt");
  a_restore_excl: assert property (
    !(exec_resume_r && exec_reset_r))
    else $error("resume and reset together");
  a_ctx_wr_pulse: assert property (
    ctx_wr_r |=> !ctx_wr_r)
    else $error("context write too long");
  cover property (exec_halt_r);
  cover property (exec_resume_r);
  cover property (exec_reset_r);
endmodule // fpc_port_monitor

bind fpc_port fpc_port_monitor mon_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .host_as_n(host_as_n), .host_ds_n(host_ds_n), .host_fc(host_fc),
  .host_id(host_id), .host_dsack_n_r(host_dsack_n_r),
  .host_rdata_r(host_rdata_r), .exec_busy(exec_busy),
  .exec_remain(exec_remain), .exec_start_r(exec_start_r),
  .exec_halt_r(exec_halt_r), .exec_resume_r(exec_resume_r),
  .exec_reset_r(exec_reset_r), .ctx_wr_r(ctx_wr_r));

// file: testbench/tb.sv
`timescale 1ns/1ps
`include "fpc_defs.vh"
module tb;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg exec_busy = 1'b0;
  reg [7:0] exec_remain = 8'h00;
  wire host_as_n, host_ds_n, host_rw, host_dsack_n_r;
  wire [2:0] host_fc, host_id;
  wire [3:0] host_reg;
  wire [1:0] host_size;
  wire [31:0] host_wdata, host_rdata_r, ctx_wdata_r;
  wire exec_start_r, exec_halt_r, exec_resume_r, exec_reset_r, ctx_wr_r;
  wire [15:0] exec_cmd_r;
  wire [79:0] exec_opnd_r;
  wire [5:0] ctx_addr_r;
  wire [31:0] ctx_rdata = {26'h2a5_a5a5, ctx_addr_r};
  integer err_total = 0, samples_checked = 0, k, f;
  integer n_st = 0, n_ht = 0, n_rs = 0, n_rt = 0, n_wr = 0;
  reg [3:0] len;
  reg [31:0] ctx_mem [0:63];
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    n_st <= n_st + exec_start_r;
    n_ht <= n_ht + exec_halt_r;
    n_rs <= n_rs + exec_resume_r;
    n_rt <= n_rt + exec_reset_r;
    n_wr <= n_wr + ctx_wr_r;
    if (ctx_wr_r)
      ctx_mem[ctx_addr_r] <= ctx_wdata_r;
  end
  fpc_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .host_as_n(host_as_n),
    .host_ds_n(host_ds_n), .host_rw(host_rw), .host_fc(host_fc),
    .host_id(host_id), .host_reg(host_reg), .host_size(host_size),
    .host_wdata(host_wdata), .host_dsack_n_r(host_dsack_n_r),
    .host_rdata_r(host_rdata_r), .exec_busy(exec_busy),
    .exec_remain(exec_remain), .exec_start_r(exec_start_r),
    .exec_cmd_r(exec_cmd_r), .exec_opnd_r(exec_opnd_r),
    .exec_halt_r(exec_halt_r), .exec_resume_r(exec_resume_r),
    .exec_reset_r(exec_reset_r), .ctx_rdata(ctx_rdata),
    .ctx_addr_r(ctx_addr_r), .ctx_wr_r(ctx_wr_r), .ctx_wdata_r(ctx_wdata_r));
  fpc_host_model host_u (.sys_clk(sys_clk), .host_dsack_n_r(host_dsack_n_r),
    .host_rdata_r(host_rdata_r), .host_as_n(host_as_n),
    .host_ds_n(host_ds_n), .host_rw(host_rw), .host_fc(host_fc),
    .host_id(host_id), .host_reg(host_reg), .host_size(host_size),
    .host_wdata(host_wdata));
  task chk(input [79:0] seen, input [79:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [3:0] r, input [1:0] sz, input [31:0] d);
    reg [31:0] q;
    reg ok;
    begin
      host_u.acc(1'b0, r, sz, d, 3'h7, 3'h1, q, ok);
      chk(ok, 1'b1);
    end
  endtask
  task rd(input [3:0] r, input [31:0] e);
    reg [31:0] q;
    reg ok;
    begin
      host_u.acc(1'b1, r, `FPC_SZ_LONG, 32'h0000_0000, 3'h7, 3'h1, q, ok);
      chk({ok, q}, {1'b1, e});
    end
  endtask
  task t_sel;
    reg [31:0] q;
    reg ok;
    begin
      rd(`FPC_IFR_SAVE, `FPC_FRAME_RESET);
      host_u.acc(1'b1, `FPC_IFR_RESP, 2'h2, 32'h0, 3'h7, 3'h2, q, ok);
      chk(ok, 1'b0);
      host_u.acc(1'b1, `FPC_IFR_RESP, 2'h2, 32'h0, 3'h5, 3'h1, q, ok);
      chk(ok, 1'b0);
    end
  endtask
  task t_fmt;
  begin
    for (f = 0; f < 6; f = f + 1)
    begin
      len = (f < 2) ? f + 1 : (f < 4) ? 4 : (f == 4) ? 8 : 12;
      wr(`FPC_IFR_CMD, `FPC_SZ_WORD, {16'h0000, 1'b1, f[2:0], 12'h000});
      rd(`FPC_IFR_RESP, `FPC_RSP_FETCH | len);
      if (f < 3)
        wr(`FPC_IFR_OPND, f[1:0], 32'h0000_0005);
      else if (f == 3)
        wr(`FPC_IFR_OPND, `FPC_SZ_LONG, 32'h40a0_0000);
      else
      begin
        wr(`FPC_IFR_OPND, `FPC_SZ_LONG,
          (f == 4) ? 32'h4014_0000 : 32'h4001_0000);
        wr(`FPC_IFR_OPND, `FPC_SZ_LONG, (f == 4) ? 32'h0 : 32'ha000_0000);
        if (f == 5)
          wr(`FPC_IFR_OPND, `FPC_SZ_LONG, 32'h0000_0000);
      end
      rd(`FPC_IFR_RESP, `FPC_RSP_DONE);
      chk(n_st, f + 1);
      chk(exec_cmd_r, {1'b1, f[2:0], 12'h000});
      if (f < 5)
        chk(exec_opnd_r, 80'h4001_a000_0000_0000_0000);
      else
        chk(exec_opnd_r, 80'h4001_a000_0000_0000_0000);
    end
  end
  endtask
  task t_wait;
  begin
    exec_busy = 1'b1;
    wr(`FPC_IFR_CMD, `FPC_SZ_WORD, 32'h0000_a000);
    wr(`FPC_IFR_OPND, `FPC_SZ_LONG, 32'h0000_0007);
    wr(`FPC_IFR_CMD, `FPC_SZ_WORD, 32'h0000_a000);
    rd(`FPC_IFR_RESP, `FPC_RSP_WAIT);
    chk(n_st, 6);
    exec_busy = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(n_st, 7);
    chk(exec_opnd_r, 80'h4001_e000_0000_0000_0000);
  end
  endtask
  task t_save;
  begin
    rd(`FPC_IFR_SAVE, {`FPC_FRAME_VER, 8'h00, `FPC_FRAME_IDLE_TAG, 2'b00,
      `FPC_IDLE_WORDS});
    for (k = 6; k >= 0; k = k - 1)
      rd(`FPC_IFR_OPND, {26'h2a5_a5a5, k[5:0]});
    exec_busy = 1'b1;
    exec_remain = 8'h2e;
    rd(`FPC_IFR_SAVE, `FPC_FRAME_AGAIN);
    exec_remain = 8'hc8;
    rd(`FPC_IFR_SAVE, {`FPC_FRAME_VER, 8'h00, `FPC_FRAME_BUSY_TAG, 2'b00,
      `FPC_BUSY_WORDS});
    chk(n_ht, 1);
    for (k = 45; k >= 0; k = k - 1)
      rd(`FPC_IFR_OPND, {26'h2a5_a5a5, k[5:0]});
    exec_busy = 1'b0;
  end
  endtask
  task t_rest;
  begin
    wr(`FPC_IFR_RESTORE, `FPC_SZ_LONG, {`FPC_FRAME_VER, 8'h00,
      `FPC_FRAME_BUSY_TAG, 2'b00, `FPC_BUSY_WORDS});
    for (k = 0; k < 46; k = k + 1)
      wr(`FPC_IFR_OPND, `FPC_SZ_LONG, {26'h2a5_a5a5, k[5:0]});
    chk(n_wr, 46);
    chk(n_rs, 1);
    chk(ctx_mem[0], {26'h2a5_a5a5, 6'h2d});
    chk(ctx_mem[45], {26'h2a5_a5a5, 6'h00});
    wr(`FPC_IFR_RESTORE, `FPC_SZ_LONG, `FPC_FRAME_RESET);
    chk(n_rt, 1);
    rd(`FPC_IFR_SAVE, `FPC_FRAME_RESET);
    wr(`FPC_IFR_RESTORE, `FPC_SZ_LONG, 32'h1234_5678);
    rd(`FPC_IFR_RESP, `FPC_RSP_ERROR);
  end
  endtask
  task t_rst;
  begin
    wr(`FPC_IFR_CMD, `FPC_SZ_WORD, 32'h0000_a000);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(`FPC_IFR_SAVE, `FPC_FRAME_RESET);
    rd(`FPC_IFR_RESP, `FPC_RSP_DONE);
    wr(`FPC_IFR_OPND, `FPC_SZ_LONG, 32'h0000_0007);
    chk(n_st, 7);
  end
  endtask
  task conclude;
  begin
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    t_sel;
    t_fmt;
    t_wait;
    t_save;
    t_rest;
    t_rst;
    conclude;
  end
  initial
  begin
    #200000;
    err_total = err_total + 1;
    conclude;
  end
endmodule // tb
